// ---- verilog/uebh_top.sv ----
// Endpoint bank handler: ping-pong or single bank, IN and OUT data,
// NAK/ACK/STALL answers, Avalon-MM register slave.
// Assumes the packet engine runs on mclk and needs no synchroniser.
`timescale 1ns/10ps
// Summary of operation
// - Ping-pong endpoint has two banks, one for CPU, one for engine.
// - Bank release sets transmit-complete; interrupt holds while set.
// - IN tokens get NAK while no bank is armed.
// - Single-bank OUT: NAK while CPU owns FIFO, else store and ACK.
// - Storing into bank 0 sets bank-0-received; interrupt holds.
// - Byte count of readable bank shows in control/status.
// - FIFO data reads return received bytes in order.
// - Clearing received flag returns bank to engine for overwrite.
// - Ping-pong OUT stores first in bank 0, next in bank 1.
// - Bank 1 fill sets bank-1-received; interrupt while either set.
// - Clearing bank-0 flag lets next OUT packet into bank 0.
// - Force-stall set makes endpoint answer with STALL.
// - Sending STALL sets stall-sent; interrupt until firmware clears.
// - Transmit-complete sets only on host ACK of IN data.
module uebh_top
  import uebh_pkg::*;
#(
  parameter int DEPTH = uebh_pkg::BANK_DEPTH
) (
  input wire logic mclk, // 200 MHz clock
  input wire logic rst, // Async reset, active high
  input wire logic ce, // Clock enable
  input wire logic [3:0] avsAddress, // Byte address
  input wire logic avsRead, // Read request
  input wire logic avsWrite, // Write request
  input wire logic [31:0] avsWritedata, // Write data
  input wire logic [3:0] avsByteenable, // Byte lanes
  output logic [31:0] avsReaddata, // Read data
  output logic avsWaitrequest, // Stall request
  input wire uebh_pkg::uebh_link_in_s lnkIn, // From packet engine
  output uebh_pkg::uebh_link_out_s lnkOut, // To packet engine
  output logic epIrq // Endpoint interrupt request
);
  import uebh_pkg::*;

  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;
  localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);

  uebh_state_e stQ;
  logic waitQ;
  logic [31:0] rdataQ;
  logic txCompQ, txCompD;
  logic stallSentQ, stallSentD;
  logic forceStallQ, pingPongQ, dirInQ;
  logic [1:0] recvQ, recvD, txArmQ, txArmD;
  logic cpuBankQ, cpuBankD, usbBankQ, usbBankD;
  logic [1:0][CW-1:0] cntQ;
  logic [CW-1:0] cpuIdxQ, usbIdxQ;
  logic dropStallQ;
  logic irqD;
  logic [15:0] memRd;
  logic [1:0] clrRecv;

  // Bus decode and access strobes
  wire busReq = avsRead | avsWrite;
  wire accDone = ce & busReq & ~avsWaitrequest;
  wire selCsr = (avsAddress == OFF_CSR);
  wire selFifo = (avsAddress == OFF_FIFO);
  wire wrCsrLo = accDone & avsWrite & selCsr & avsByteenable[0];
  wire wrCsrHi = accDone & avsWrite & selCsr & avsByteenable[1];
  wire [31:0] wd = avsWritedata;
  wire armReq = wrCsrLo & wd[BIT_TXRDY] & dirInQ;
  wire clrTxComp = wrCsrLo & wd[BIT_TX_COMPLETE];
  wire clrStall = wrCsrLo & wd[BIT_STALL_SENT_B];
  assign clrRecv[0] = wrCsrLo & wd[BIT_RECV0];
  assign clrRecv[1] = wrCsrLo & wd[BIT_RECV1];

  // CPU FIFO access: IN writes append, OUT reads pop in order
  wire [CW-1:0] cpuCnt = cntQ[cpuBankQ];
  wire cpuFull = (cpuCnt >= DEPTH_C);
  wire fifoWr = accDone & avsWrite & selFifo & avsByteenable[0] & dirInQ
    & ~txArmQ[cpuBankQ] & ~cpuFull;
  wire fifoRd = accDone & avsRead & selFifo & ~dirInQ;
  wire clrCpuBank = clrRecv[cpuBankQ] & recvQ[cpuBankQ];

  // Engine-side view of the current bank
  wire [CW-1:0] usbCnt = cntQ[usbBankQ];
  wire usbArmed = txArmQ[usbBankQ];
  wire rxFree = ~recvQ[usbBankQ];
  wire inIdle = (stQ == ST_IDLE);
  wire evTxRel = ce & (stQ == ST_TXWAIT) & lnkIn.hostAck;
  wire evRxStore = ce & (stQ == ST_RX) & lnkIn.rxEnd;
  wire evStallIn = ce & inIdle & lnkIn.tokIn & forceStallQ;
  wire evStallOut = ce & (stQ == ST_RXDROP) & lnkIn.rxEnd & dropStallQ;
  wire rxWr = ce & (stQ == ST_RX) & lnkIn.rxValid & (usbIdxQ < DEPTH_C);

  // Memory port selection
  wire memWrEn = fifoWr | rxWr;
  wire memWrBank = dirInQ ? cpuBankQ : usbBankQ;
  wire [AW-1:0] memWrAddr = dirInQ ? cpuCnt[AW-1:0] : usbIdxQ[AW-1:0];
  wire [7:0] memWrData = dirInQ ? wd[7:0] : lnkIn.rxByte;
  wire [7:0] cpuRdByte = memRd[7:0];
  wire [7:0] usbRdByte = memRd[15:8];

  // Read data mux
  wire [31:0] csrView = {{(16-CW){1'b0}}, cpuCnt, 6'h00, dirInQ, pingPongQ,
    1'b0, recvQ[1], forceStallQ, |txArmQ, stallSentQ, 1'b0, recvQ[0],
    txCompQ};
  wire [31:0] rdMux = selCsr ? csrView :
    selFifo ? {24'h00_0000, cpuRdByte} : RD_UNMAPPED;

  uebh_bank_mem #(
    .DEPTH(DEPTH),
    .AW(AW)
  ) u_mem (
    .mclk(mclk),
    .ce(ce),
    .wrEn(memWrEn),
    .wrBank(memWrBank),
    .wrAddr(memWrAddr),
    .wrData(memWrData),
    .rdBank({usbBankQ, cpuBankQ}),
    .rdAddr({usbIdxQ[AW-1:0], cpuIdxQ[AW-1:0]}),
    .rdData(memRd)
  );

  // Avalon slave: one wait cycle, data latched on the first cycle
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      waitQ <= 1'b1;
      rdataQ <= 32'h0000_0000;
    end else if (ce) begin
      waitQ <= ~(busReq & waitQ);
      if (busReq & waitQ) begin
        rdataQ <= rdMux;
      end
    end
  end
  assign avsWaitrequest = waitQ;
  assign avsReaddata = rdataQ;

  // Control bits written by software
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      forceStallQ <= CSR_RESET[BIT_FSTALL];
      pingPongQ <= CSR_RESET[BIT_PINGPONG];
      dirInQ <= CSR_RESET[BIT_DIRIN];
    end else begin
      if (wrCsrLo) begin
        forceStallQ <= wd[BIT_FSTALL];
      end
      if (wrCsrHi) begin
        pingPongQ <= wd[BIT_PINGPONG];
        dirInQ <= wd[BIT_DIRIN];
      end
    end
  end

  // Flag, arm and bank pointer next values; a set beats a clear
  always_comb begin
    txCompD = (txCompQ & ~clrTxComp) | evTxRel;
    stallSentD = (stallSentQ & ~clrStall) | evStallIn
      | evStallOut;
    for (int b = 0; b < 2; b++) begin
      recvD[b] = (recvQ[b] & ~clrRecv[b])
        | (evRxStore & (usbBankQ == b[0]));
      txArmD[b] = (txArmQ[b] & ~(evTxRel & (usbBankQ == b[0])))
        | (armReq & (cpuBankQ == b[0]));
    end
    usbBankD = usbBankQ ^ (pingPongQ & (evTxRel | evRxStore));
    cpuBankD = cpuBankQ ^ (pingPongQ & (armReq | clrCpuBank));
    irqD = txCompD | stallSentD | (|recvD);
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      txCompQ <= 1'b0;
      stallSentQ <= 1'b0;
      recvQ <= 2'b00;
      txArmQ <= 2'b00;
      usbBankQ <= 1'b0;
      cpuBankQ <= 1'b0;
      epIrq <= 1'b0;
    end else if (ce) begin
      txCompQ <= txCompD;
      stallSentQ <= stallSentD;
      recvQ <= recvD;
      txArmQ <= txArmD;
      usbBankQ <= usbBankD;
      cpuBankQ <= cpuBankD;
      epIrq <= irqD;
    end
  end

  // Byte counts per bank and CPU read pointer
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cntQ <= '0;
      cpuIdxQ <= '0;
    end else if (ce) begin
      if (fifoWr) begin
        cntQ[cpuBankQ] <= cpuCnt + 1'b1;
      end
      if (evRxStore) begin
        cntQ[usbBankQ] <= usbIdxQ;
      end else if (evTxRel) begin
        cntQ[usbBankQ] <= '0;
      end
      if (clrCpuBank) begin
        cpuIdxQ <= '0;
      end else if (fifoRd && cpuIdxQ < DEPTH_C) begin
        cpuIdxQ <= cpuIdxQ + 1'b1;
      end
    end
  end

  // Packet engine: token answers, IN streaming, OUT storing
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      stQ <= ST_IDLE;
      usbIdxQ <= '0;
      dropStallQ <= 1'b0;
      lnkOut <= '0;
    end else if (ce) begin
      lnkOut <= '0;
      case (stQ)
        ST_IDLE: begin
          usbIdxQ <= '0;
          if (lnkIn.tokIn) begin
            if (forceStallQ) begin
              lnkOut.hsValid <= 1'b1;
              lnkOut.hsCode <= HS_STALL;
            end else if (dirInQ && usbArmed) begin
              stQ <= ST_TX;
            end else begin
              lnkOut.hsValid <= 1'b1;
              lnkOut.hsCode <= HS_NAK;
            end
          end else if (lnkIn.tokOut) begin
            dropStallQ <= forceStallQ;
            if (!forceStallQ && !dirInQ && rxFree) begin
              stQ <= ST_RX;
            end else begin
              stQ <= ST_RXDROP;
            end
          end
        end
        ST_TX: begin
          if (usbIdxQ == usbCnt) begin
            lnkOut.txEnd <= 1'b1;
            stQ <= ST_TXWAIT;
          end else begin
            lnkOut.txValid <= 1'b1;
            lnkOut.txByte <= usbRdByte;
            usbIdxQ <= usbIdxQ + 1'b1;
          end
        end
        ST_TXWAIT: begin
          if (lnkIn.hostAck) begin
            stQ <= ST_IDLE;
          end else if (lnkIn.tokIn) begin
            usbIdxQ <= '0;
            stQ <= ST_TX;
          end
        end
        ST_RX: begin
          if (rxWr) begin
            usbIdxQ <= usbIdxQ + 1'b1;
          end
          if (lnkIn.rxEnd) begin
            lnkOut.hsValid <= 1'b1;
            lnkOut.hsCode <= HS_ACK;
            stQ <= ST_IDLE;
          end
        end
        ST_RXDROP: begin
          if (lnkIn.rxEnd) begin
            lnkOut.hsValid <= 1'b1;
            lnkOut.hsCode <= dropStallQ ? HS_STALL : HS_NAK;
            stQ <= ST_IDLE;
          end
        end
        default: begin
          stQ <= ST_IDLE;
        end
      endcase
    end
  end

  // Checks and scenario covers
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  chk_irq_tx_complete: assert property (txCompQ |-> epIrq)
    else $error("irq low while transmit-complete set");
  chk_irq_recv0: assert property (recvQ[0] |-> epIrq)
    else $error("irq low while bank 0 received");
  chk_irq_either: assert property (
    (recvQ[0] | recvQ[1] | stallSentQ) |-> epIrq)
    else $error("irq low while a flag is set");
  chk_stall_answer: assert property (
    ce && inIdle && lnkIn.tokIn && forceStallQ
    |=> lnkOut.hsValid && lnkOut.hsCode == HS_STALL)
    else $error("stall not answered");
  chk_stall_flag: assert property (
    lnkOut.hsValid && lnkOut.hsCode == HS_STALL |-> stallSentQ)
    else $error("stall sent without flag");
  chk_nak_unarmed: assert property (
    ce && inIdle && lnkIn.tokIn && !forceStallQ && !usbArmed
    |=> lnkOut.hsValid && lnkOut.hsCode == HS_NAK)
    else $error("unarmed IN not NAKed");
  chk_tx_complete_ack: assert property (
    $rose(txCompQ) |-> $past(lnkIn.hostAck) && $past(stQ) == ST_TXWAIT)
    else $error("transmit-complete without ACK");
  chk_single_nak: assert property (
    ce && inIdle && lnkIn.tokOut && !lnkIn.tokIn && !pingPongQ
    && recvQ[0] |=> stQ == ST_RXDROP ##[1:300] lnkOut.hsValid)
    else $error("busy single bank not refused");
  chk_bank_toggle: assert property (
    evTxRel && pingPongQ |=> usbBankQ != $past(usbBankQ))
    else $error("bank pointer did not toggle");

  cov_in_done: cover property (evTxRel ##1 txCompQ);
  cov_both_banks: cover property (recvQ == 2'b11);
  cov_stall_sent: cover property ($rose(stallSentQ));
endmodule // uebh_top

// ---- pkg/uebh_pkg.sv ----
// Shared constants, link carriers and state codes for the endpoint
// bank handler. Assumes a single 200 MHz clock domain.
package uebh_pkg;
  // Register byte offsets on the Avalon-MM slave
  localparam logic [3:0] OFF_CSR = 4'h0;
  localparam logic [3:0] OFF_FIFO = 4'h4;
  // Control/status field positions
  localparam int BIT_TX_COMPLETE = 0;
  localparam int BIT_RECV0 = 1;
  localparam int BIT_STALL_SENT_B = 3;
  localparam int BIT_TXRDY = 4;
  localparam int BIT_FSTALL = 5;
  localparam int BIT_RECV1 = 6;
  localparam int BIT_PINGPONG = 8;
  localparam int BIT_DIRIN = 9;
  localparam int POS_BYTECNT = 16;
  // Reset value and unmapped read value
  localparam logic [31:0] CSR_RESET = 32'h0000_0000;
  localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;
  // Bank geometry defaults
  localparam int BANK_DEPTH = 64;
  localparam int BYTE_W = 8;
  // Handshake codes
  localparam logic [1:0] HS_ACK = 2'h0;
  localparam logic [1:0] HS_NAK = 2'h1;
  localparam logic [1:0] HS_STALL = 2'h2;
  // Engine states
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_TX = 5'b00010,
    ST_TXWAIT = 5'b00100,
    ST_RX = 5'b01000,
    ST_RXDROP = 5'b10000
  } uebh_state_e;
  // Packet engine to endpoint: tokens, host ack, received bytes
  typedef struct packed {
    logic tokIn;
    logic tokOut;
    logic hostAck;
    logic rxValid;
    logic [7:0] rxByte;
    logic rxEnd;
  } uebh_link_in_s;
  // Endpoint to packet engine: handshake and IN payload
  typedef struct packed {
    logic hsValid;
    logic [1:0] hsCode;
    logic txValid;
    logic [7:0] txByte;
    logic txEnd;
  } uebh_link_out_s;
endpackage

// ---- verilog/uebh_bank_mem.sv ----
// Two-bank byte store for one endpoint, one write port, two read ports.
// Assumes the caller never writes the same bank from both sides at once.
`timescale 1ns/10ps
module uebh_bank_mem #(
  parameter int DEPTH = 64,
  parameter int AW = 6
) (
  input wire logic mclk, // Clock
  input wire logic ce, // Clock enable
  input wire logic wrEn, // Write strobe
  input wire logic wrBank, // Bank written
  input wire logic [AW-1:0] wrAddr, // Byte index written
  input wire logic [7:0] wrData, // Byte written
  input wire logic [1:0] rdBank, // Bank per read port
  input wire logic [2*AW-1:0] rdAddr, // Index per read port
  output logic [15:0] rdData // Byte per read port
);
  logic [7:0] mem [2*DEPTH];

  // Byte write into the selected bank
  always_ff @(posedge mclk) begin
    if (ce && wrEn) begin
      mem[{wrBank, wrAddr}] <= wrData;
    end
  end

  // Asynchronous read ports
  for (genvar p = 0; p < 2; p++) begin : g_rd
    assign rdData[8*p +: 8] = mem[{rdBank[p], rdAddr[AW*p +: AW]}];
  end
endmodule // uebh_bank_mem

// ---- sim/uebh_host_model.sv ----
// Host-side model of the full-speed packet engine for one endpoint.
// Assumes link signals are mclk-synchronous, handshakes are 1-cycle pulses.
`timescale 1ns/10ps
module uebh_host_model
  import uebh_pkg::*;
(
  input wire logic mclk, // Clock
  input wire uebh_pkg::uebh_link_out_s lnkOut, // From endpoint
  output uebh_pkg::uebh_link_in_s lnkIn // To endpoint
);
  import uebh_pkg::*;
  logic [7:0] got[$];
  logic [1:0] code;

  initial lnkIn = '0;

  // One link cycle: tokIn,tokOut,hostAck,rxValid,rxEnd plus a byte
  task automatic drive(input logic [4:0] f, input logic [7:0] b);
    @(posedge mclk);
    lnkIn <= {f[4:1], b, f[0]};
  endtask

  // Idle byte lane toggles so stale data is never mistaken for valid
  task automatic idle();
    lnkIn <= {4'h0, ~lnkIn.rxByte, 1'b0};
  endtask

  // OUT transaction; slow inserts a gap after every byte
  task automatic sendOut(input int n, input logic [7:0] b, input logic slow);
    drive(5'b01000, ~b);
    for (int i = 0; i < n; i++) begin
      drive(5'b00010, b + 8'(i));
      if (slow)
        drive(5'b00000, ~b);
    end
    drive(5'b00001, ~b);
    code = 2'h3;
    repeat (10) begin
      @(posedge mclk);
      idle();
      if (lnkOut.hsValid === 1'b1) begin
        code = lnkOut.hsCode;
        break;
      end
    end
  endtask

  // IN transaction; bytes collected in got, host ACK only if ack set
  task automatic sendIn(input logic ack);
    got.delete();
    code = 2'h3;
    drive(5'b10000, 8'h00);
    repeat (80) begin
      @(posedge mclk);
      idle();
      if (lnkOut.hsValid === 1'b1) begin
        code = lnkOut.hsCode;
        break;
      end
      if (lnkOut.txValid === 1'b1)
        got.push_back(lnkOut.txByte);
      if (lnkOut.txEnd === 1'b1)
        break;
    end
    if (ack && code == 2'h3) begin
      drive(5'b00100, 8'h00);
      drive(5'b00000, 8'hFF);
      repeat (2) @(posedge mclk);
    end
  endtask
endmodule // uebh_host_model

// ---- sim/usb_endpoint_bank_handler_tb.sv ----
// Self-checking bench: firmware register sequences against the endpoint.
// Assumes uebh_top with one wait cycle per Avalon access.
`timescale 1ns/10ps
module usb_endpoint_bank_handler_tb;
  import uebh_pkg::*;
  logic mclk, rst, ce, avsRead, avsWrite, avsWaitrequest, epIrq;
  logic [3:0] avsAddress, avsByteenable;
  logic [31:0] avsWritedata, avsReaddata, q;
  uebh_link_in_s lnkIn;
  uebh_link_out_s lnkOut;
  int failures, samplesChecked;

  uebh_top #(.DEPTH(64)) dut (.mclk(mclk), .rst(rst), .ce(ce),
    .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
    .avsWritedata(avsWritedata), .avsByteenable(avsByteenable),
    .avsReaddata(avsReaddata), .avsWaitrequest(avsWaitrequest),
    .lnkIn(lnkIn), .lnkOut(lnkOut), .epIrq(epIrq));
  uebh_host_model host (.mclk(mclk), .lnkOut(lnkOut), .lnkIn(lnkIn));

  // Clock
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    if (failures == 0 && samplesChecked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Avalon access held until waitrequest is sampled low; hang guard ends it
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [31:0] d);
    @(posedge mclk);
    avsAddress <= a;
    avsWritedata <= d;
    avsWrite <= wr;
    avsRead <= !wr;
    do begin
      @(posedge mclk);
    end while (avsWaitrequest !== 1'b0);
    q = avsReaddata;
    avsWrite <= 1'b0;
    avsRead <= 1'b0;
  endtask

  task automatic rdChk(input logic [3:0] a, input logic [31:0] m,
                       input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000);
    check(q & m, e);
  endtask

  // Interrupt looked at one edge after a write lands, once it has settled
  task automatic irqChk(input logic e);
    @(posedge mclk);
    check(epIrq, e);
  endtask

  task automatic gotChk(input int n, input logic [7:0] b);
    check(host.got.size(), n);
    foreach (host.got[i])
      check(host.got[i], b + 8'(i));
  endtask

  task automatic doReset();
    @(posedge mclk);
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
  endtask

  // Hang guard
  initial begin
    repeat (20000) @(posedge mclk);
    failures++;
    conclude();
  end

  initial begin
    rst = 1'b1;
    ce = 1'b1;
    avsAddress = 4'h0;
    avsRead = 1'b0;
    avsWrite = 1'b0;
    avsWritedata = 32'h0000_0000;
    avsByteenable = 4'hF;
    failures = 0;
    samplesChecked = 0;
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    // Reset state and unmapped space
    rdChk(OFF_CSR, 32'hFFFF_FFFF, CSR_RESET);
    rdChk(4'h8, 32'hFFFF_FFFF, RD_UNMAPPED);
    bus(1'b1, 4'hC, 32'hFFFF_FFFF);
    // Write on the upper lanes only must leave the register untouched
    avsByteenable <= 4'hC;
    bus(1'b1, OFF_CSR, 32'h0000_0331);
    avsByteenable <= 4'hF;
    rdChk(OFF_CSR, 32'hFFFF_FFFF, CSR_RESET);
    // Single-bank OUT with slow host, NAK while CPU owns the bank
    host.sendOut(3, 8'h50, 1'b1);
    check(host.code, HS_ACK);
    rdChk(OFF_CSR, 32'hFFFF_FFFF, 32'h0003_0002);
    check(epIrq, 1'b1);
    host.sendOut(1, 8'h60, 1'b0);
    check(host.code, HS_NAK);
    for (int i = 0; i < 3; i++)
      rdChk(OFF_FIFO, 32'h0000_00FF, 32'h50 + i);
    bus(1'b1, OFF_CSR, 32'h0000_0002);
    irqChk(1'b0);
    host.sendOut(2, 8'h70, 1'b0);
    check(host.code, HS_ACK);
    // Ping-pong OUT: two banks filled back to back, then alternate
    doReset();
    bus(1'b1, OFF_CSR, 32'h0000_0100);
    host.sendOut(2, 8'h10, 1'b0);
    check(host.code, HS_ACK);
    host.sendOut(3, 8'h20, 1'b0);
    check(host.code, HS_ACK);
    host.sendOut(1, 8'h30, 1'b0);
    check(host.code, HS_NAK);
    rdChk(OFF_CSR, 32'hFFFF_FFFF, 32'h0002_0142);
    for (int i = 0; i < 2; i++)
      rdChk(OFF_FIFO, 32'h0000_00FF, 32'h10 + i);
    bus(1'b1, OFF_CSR, 32'h0000_0102);
    rdChk(OFF_CSR, 32'hFFFF_FFFF, 32'h0003_0140);
    check(epIrq, 1'b1);
    host.sendOut(1, 8'h30, 1'b0);
    check(host.code, HS_ACK);
    for (int i = 0; i < 3; i++)
      rdChk(OFF_FIFO, 32'h0000_00FF, 32'h20 + i);
    bus(1'b1, OFF_CSR, 32'h0000_0140);
    rdChk(OFF_CSR, 32'hFFFF_FFFF, 32'h0001_0102);
    rdChk(OFF_FIFO, 32'h0000_00FF, 32'h0000_0030);
    // Ping-pong IN: NAK unarmed, preload, retry without ACK, swap
    doReset();
    bus(1'b1, OFF_CSR, 32'h0000_0300);
    host.sendIn(1'b1);
    check(host.code, HS_NAK);
    rdChk(OFF_CSR, 32'h0000_0010, 32'h0000_0000);
    for (int i = 0; i < 2; i++)
      bus(1'b1, OFF_FIFO, 32'hA0 + i);
    bus(1'b1, OFF_CSR, 32'h0000_0310);
    for (int i = 0; i < 3; i++)
      bus(1'b1, OFF_FIFO, 32'hB0 + i);
    rdChk(OFF_CSR, 32'h0000_0011, 32'h0000_0010);
    host.sendIn(1'b0);
    gotChk(2, 8'hA0);
    rdChk(OFF_CSR, 32'h0000_0001, 32'h0000_0000);
    host.sendIn(1'b1);
    gotChk(2, 8'hA0);
    rdChk(OFF_CSR, 32'h0000_0001, 32'h0000_0001);
    check(epIrq, 1'b1);
    bus(1'b1, OFF_CSR, 32'h0000_0310);
    bus(1'b1, OFF_CSR, 32'h0000_0301);
    irqChk(1'b0);
    host.sendIn(1'b1);
    gotChk(3, 8'hB0);
    // Forced stall on both token kinds, flag cleared by firmware
    doReset();
    bus(1'b1, OFF_CSR, 32'h0000_0020);
    // Clock enable low: token ignored, no stall sent, no flag
    @(posedge mclk);
    ce <= 1'b0;
    host.sendIn(1'b0);
    @(posedge mclk);
    ce <= 1'b1;
    check(host.code, 2'h3);
    rdChk(OFF_CSR, 32'h0000_0008, 32'h0000_0000);
    host.sendOut(1, 8'h01, 1'b0);
    check(host.code, HS_STALL);
    host.sendIn(1'b1);
    check(host.code, HS_STALL);
    rdChk(OFF_CSR, 32'h0000_0028, 32'h0000_0028);
    check(epIrq, 1'b1);
    bus(1'b1, OFF_CSR, 32'h0000_0008);
    irqChk(1'b0);
    conclude();
  end
endmodule // usb_endpoint_bank_handler_tb
